/* rtl/phpp_pkg.sv */
// Shared constants, types and decoders for the parallel programming port.
// Assumes a single 100 MHz clock domain inside the device.
package phpp_pkg;

  // ****************************************************************
  // Pin vector layout after synchronisation.
  // ****************************************************************
  localparam int          PIN_W         = 17;
  localparam int          PIN_DATA_LSB  = 0;
  localparam int          PIN_LATCH     = 8;
  localparam int          PIN_ACT0      = 9;
  localparam int          PIN_ACT1      = 10;
  localparam int          PIN_SELX      = 11;
  localparam int          PIN_SELH      = 12;
  localparam int          PIN_OE_N      = 13;
  localparam int          PIN_STORE_N   = 14;
  localparam int          PIN_LOAD      = 15;
  localparam int          PIN_HV        = 16;
  localparam logic [16:0] PIN_IDLE      = 17'h06000;

  // ****************************************************************
  // Action codes, commands and memory geometry.
  // ****************************************************************
  localparam logic [1:0] ACT_ADDR     = 2'h0;
  localparam logic [1:0] ACT_DATA     = 2'h1;
  localparam logic [1:0] ACT_CMD      = 2'h2;
  localparam logic [1:0] ACT_IDLE     = 2'h3;
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP   = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP   = 8'h03;
  localparam int         WORD_IN_PAGE_W = 7;
  localparam int         FLASH_PAGE_W   = 8;
  localparam int         FLASH_ADDR_W   = 15;
  localparam int         EEP_ADDR_W     = 11;
  localparam int         EEP_BYTE_W     = 3;
  localparam int         KEEP_EEP_BIT   = 3;

  // ****************************************************************
  // Values after reset and timing.
  // ****************************************************************
  localparam logic [7:0] FUSE_LOW_RST  = 8'h62;
  localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
  localparam logic [7:0] FUSE_EXT_RST  = 8'hff;
  localparam logic [7:0] LOCK_ERASED   = 8'hff;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         FUSE_WRITE_NS = 4500;
  localparam int         FUSE_WRITE_CYC =
    (FUSE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         FUSE_TIMER_W  = $clog2(FUSE_WRITE_CYC + 1);

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {BSEL_LOW, BSEL_HIGH, BSEL_EXT, BSEL_RSVD} phpp_bsel_e;
  typedef enum logic [2:0] {
    NVM_NONE, NVM_FLASH_PAGE, NVM_EEP_PAGE, NVM_ERASE_FLASH, NVM_ERASE_SRAM, NVM_ERASE_EEP
  } phpp_nvm_op_e;
  typedef enum logic [2:0] {
    ST_OFF, ST_IDLE, ST_NVM_WAIT, ST_ER_FLASH, ST_ER_SRAM, ST_ER_EEP, ST_FUSE
  } phpp_state_e;

  // Byte selection from the two select pins.
  function automatic phpp_bsel_e phpp_bsel(input logic bs2, input logic bs1);
    case ({bs2, bs1})
      2'h0:    phpp_bsel = BSEL_LOW;
      2'h1:    phpp_bsel = BSEL_HIGH;
      2'h2:    phpp_bsel = BSEL_EXT;
      default: phpp_bsel = BSEL_RSVD;
    endcase
  endfunction

endpackage

/* rtl/phpp_page_mem.sv */
// Page buffer memory: one write port, one read port with registered data.
// Assumes writer and reader share the clock.
`timescale 1ns/100ps
`default_nettype none
module phpp_page_mem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  // Clock and reset.
  input  wire logic          i_clock,
  input  wire logic          i_reset_n,
  // Write side.
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read side.
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

/* rtl/phpp_port.sv */
// Device end of the high-voltage parallel programming port.
// Assumes the memory arrays sit outside behind the nvm start/done handshake.
// Notes on behaviour
// - Flash pages hold 128 words; word bits 6:0 in page, 14:7 select page.
// - EEPROM has 8-byte pages; address bits 2:0 select byte in page.
// - Ready output low during program or erase, high when commands accepted.
// - Data bus driven only while output enable is low.
// - Store strobe or output enable performs the loaded command's action.
// - Load strobe action codes: address, data, command, or nothing.
// - Byte selects pick low, high or extended byte; both high reserved.
// - Fuse read: low fuse, lock bits, extended fuse, high fuse by select code.
// - Programming mode ends on power down or reset pin low.
// - Write command codes: erase, fuses, locks, flash, EEPROM.
// - Read command codes: signature, fuses and locks, flash, EEPROM.
// - Loaded command and address stay until reloaded.
// - Erase clears flash, then locks, then SRAM and EEPROM; fuses untouched.
// - Programmed keep-EEPROM fuse excludes EEPROM from erase.
// - Erase command then store strobe; busy until erase completes.
// - Flash data gathers in a page buffer, programmed as one page.
// - Data bytes load with action 01, high or low by first select.
// - Store strobe starts page programming; busy until it completes.
`timescale 1ns/100ps
`default_nettype none
module phpp_port #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,  // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE1 = 8'h3c,  // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE2 = 8'h01,  // Arbitrary identity value.
  parameter logic [7:0] CAL_BYTE  = 8'h80
) (
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_reset_n,
  // Programming pins.
  input  wire logic                 i_prog_voltage,
  input  wire logic                 i_load_strobe,
  input  wire logic                 i_store_strobe_n,
  input  wire logic                 i_output_enable_n,
  input  wire logic                 i_byte_select_high,
  input  wire logic                 i_byte_select_extended,
  input  wire logic                 i_strobe_action_bit0,
  input  wire logic                 i_strobe_action_bit1,
  input  wire logic                 i_page_latch_strobe,
  input  wire logic [7:0]           i_data,
  output logic      [7:0]           o_data,
  output logic                      o_data_oe,
  output logic                      o_ready_not_busy,
  // Status.
  output logic                      o_prog_mode,
  output logic      [7:0]           o_fuse_low,
  output logic      [7:0]           o_fuse_high,
  output logic      [7:0]           o_fuse_ext,
  output logic      [7:0]           o_lock,
  // Memory array side.
  output logic                      o_nvm_start,
  output phpp_pkg::phpp_nvm_op_e    o_nvm_op,
  output logic      [7:0]           o_nvm_page,
  input  wire logic                 i_nvm_done,
  input  wire logic [6:0]           i_nvm_buf_index,
  output logic      [15:0]          o_nvm_buf_word,
  output logic      [14:0]          o_flash_rd_addr,
  input  wire logic [15:0]          i_flash_rd_data,
  output logic      [10:0]          o_eep_rd_addr,
  input  wire logic [7:0]           i_eep_rd_data
);
  import phpp_pkg::*;

  // ****************************************************************
  // Pin synchronisers: a change counts once stages two and three agree.
  // ****************************************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] clean;
  logic [PIN_W-1:0] clean_d;
  logic [PIN_W-1:0] next_clean;

  assign pin_raw = {i_prog_voltage, i_load_strobe, i_store_strobe_n, i_output_enable_n,
                    i_byte_select_high, i_byte_select_extended, i_strobe_action_bit1,
                    i_strobe_action_bit0, i_page_latch_strobe, i_data};

  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_filt
      assign next_clean[g] = (sync2[g] == sync3[g]) ? sync3[g] : clean[g];
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      sync1   <= PIN_IDLE;
      sync2   <= PIN_IDLE;
      sync3   <= PIN_IDLE;
      clean   <= PIN_IDLE;
      clean_d <= PIN_IDLE;
    end else begin
      sync1   <= pin_raw;
      sync2   <= sync1;
      sync3   <= sync2;
      clean   <= next_clean;
      clean_d <= clean;
    end
  end

  logic       load_rise;
  logic       store_fall;
  logic       latch_rise;
  logic       hv_rise;
  logic       oe_act;
  logic [1:0] action;
  logic [7:0] pin_data;
  phpp_bsel_e bsel;

  assign load_rise  = clean[PIN_LOAD] & ~clean_d[PIN_LOAD];
  assign store_fall = ~clean[PIN_STORE_N] & clean_d[PIN_STORE_N];
  assign latch_rise = clean[PIN_LATCH] & ~clean_d[PIN_LATCH];
  assign hv_rise    = clean[PIN_HV] & ~clean_d[PIN_HV];
  assign oe_act     = ~clean[PIN_OE_N];
  assign action     = {clean[PIN_ACT1], clean[PIN_ACT0]};
  assign pin_data   = clean[PIN_DATA_LSB +: 8];
  assign bsel       = phpp_bsel(clean[PIN_SELX], clean[PIN_SELH]);

  // ****************************************************************
  // Control state.
  // ****************************************************************
  logic                    prog;
  logic                    next_prog;
  phpp_state_e             state;
  phpp_state_e             next_state;
  logic [7:0]              cmd;
  logic [7:0]              next_cmd;
  logic [7:0]              addr_low;
  logic [7:0]              next_addr_low;
  logic [7:0]              addr_high;
  logic [7:0]              next_addr_high;
  logic [7:0]              addr_ext;
  logic [7:0]              next_addr_ext;
  logic [7:0]              data_low;
  logic [7:0]              next_data_low;
  logic [7:0]              data_high;
  logic [7:0]              next_data_high;
  logic [7:0]              fuse_low;
  logic [7:0]              next_fuse_low;
  logic [7:0]              fuse_high;
  logic [7:0]              next_fuse_high;
  logic [7:0]              fuse_ext;
  logic [7:0]              next_fuse_ext;
  logic [7:0]              lock;
  logic [7:0]              next_lock;
  logic [FUSE_TIMER_W-1:0] timer;
  logic [FUSE_TIMER_W-1:0] next_timer;
  logic                    nvm_start;
  logic                    next_nvm_start;
  phpp_nvm_op_e            nvm_op;
  phpp_nvm_op_e            next_nvm_op;
  logic [7:0]              nvm_page;
  logic [7:0]              next_nvm_page;
  logic [7:0]              data_out;
  logic [7:0]              next_data_out;
  logic [7:0]              rd_byte;
  logic                    buf_we;
  logic [6:0]              buf_waddr;

  assign o_flash_rd_addr = {addr_high[6:0], addr_low};
  assign o_eep_rd_addr   = {addr_high[2:0], addr_low};

  // Read data selection by loaded command.
  always_comb begin
    case (cmd)
      CMD_RD_FLASH: rd_byte = (bsel == BSEL_HIGH) ? i_flash_rd_data[15:8]
                                                  : i_flash_rd_data[7:0];
      CMD_RD_EEP:   rd_byte = i_eep_rd_data;
      CMD_RD_FUSE: begin
        case (bsel)
          BSEL_LOW:  rd_byte = fuse_low;
          BSEL_HIGH: rd_byte = lock;
          BSEL_EXT:  rd_byte = fuse_ext;
          default:   rd_byte = fuse_high;
        endcase
      end
      CMD_RD_SIG: begin
        if (bsel == BSEL_HIGH) begin
          rd_byte = CAL_BYTE;
        end else begin
          case (addr_low[1:0])
            2'h0:    rd_byte = SIG_BYTE0;
            2'h1:    rd_byte = SIG_BYTE1;
            2'h2:    rd_byte = SIG_BYTE2;
            default: rd_byte = 8'hff;
          endcase
        end
      end
      default: rd_byte = 8'hff;
    endcase
  end

  // Page latch writes the loaded data into the page buffer.
  assign buf_we    = prog && latch_rise && (state == ST_IDLE);
  assign buf_waddr = (cmd == CMD_WR_EEP) ? {4'h0, addr_low[EEP_BYTE_W-1:0]}
                                         : addr_low[WORD_IN_PAGE_W-1:0];

  always_comb begin
    next_prog      = prog;
    next_state     = state;
    next_cmd       = cmd;
    next_addr_low  = addr_low;
    next_addr_high = addr_high;
    next_addr_ext  = addr_ext;
    next_data_low  = data_low;
    next_data_high = data_high;
    next_fuse_low  = fuse_low;
    next_fuse_high = fuse_high;
    next_fuse_ext  = fuse_ext;
    next_lock      = lock;
    next_timer     = timer;
    next_nvm_start = 1'b0;
    next_nvm_op    = nvm_op;
    next_nvm_page  = nvm_page;
    next_data_out  = (prog && oe_act) ? rd_byte : data_out;
    if (!clean[PIN_HV]) begin
      next_prog  = 1'b0;
      next_state = ST_OFF;
    end else if (hv_rise) begin
      next_prog  = ({clean[PIN_LATCH], action, clean[PIN_SELH]} == 4'h0);
      next_state = ST_IDLE;
      next_cmd   = CMD_NOP;
    end else if (prog) begin
      if (load_rise) begin
        case (action)
          ACT_ADDR: begin
            case (bsel)
              BSEL_LOW:  next_addr_low  = pin_data;
              BSEL_HIGH: next_addr_high = pin_data;
              BSEL_EXT:  next_addr_ext  = pin_data;
              default:   next_addr_ext  = addr_ext;
            endcase
          end
          ACT_DATA: begin
            if (bsel == BSEL_HIGH) begin
              next_data_high = pin_data;
            end else if (bsel == BSEL_LOW) begin
              next_data_low = pin_data;
            end
          end
          ACT_CMD: next_cmd = pin_data;
          default: next_cmd = cmd;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (store_fall) begin
            case (cmd)
              CMD_ERASE: begin
                next_state     = ST_ER_FLASH;
                next_nvm_op    = NVM_ERASE_FLASH;
                next_nvm_start = 1'b1;
              end
              CMD_WR_FLASH: begin
                next_state     = ST_NVM_WAIT;
                next_nvm_op    = NVM_FLASH_PAGE;
                next_nvm_start = 1'b1;
                next_nvm_page  = {addr_high[6:0], addr_low[7]};
              end
              CMD_WR_EEP: begin
                next_state     = ST_NVM_WAIT;
                next_nvm_op    = NVM_EEP_PAGE;
                next_nvm_start = 1'b1;
                next_nvm_page  = {addr_high[2:0], addr_low[7:3]};
              end
              CMD_WR_FUSE: begin
                case (bsel)
                  BSEL_LOW:  next_fuse_low  = data_low;
                  BSEL_HIGH: next_fuse_high = data_low;
                  BSEL_EXT:  next_fuse_ext  = data_low;
                  default:   next_fuse_ext  = fuse_ext;
                endcase
                next_state = ST_FUSE;
                next_timer = '0;
              end
              CMD_WR_LOCK: begin
                next_lock  = lock & data_low;
                next_state = ST_FUSE;
                next_timer = '0;
              end
              default: next_state = ST_IDLE;
            endcase
          end
        end
        ST_NVM_WAIT: begin
          if (i_nvm_done) begin
            next_state = ST_IDLE;
          end
        end
        ST_ER_FLASH: begin
          if (i_nvm_done) begin
            next_lock      = LOCK_ERASED;
            next_state     = ST_ER_SRAM;
            next_nvm_op    = NVM_ERASE_SRAM;
            next_nvm_start = 1'b1;
          end
        end
        ST_ER_SRAM: begin
          if (i_nvm_done) begin
            if (fuse_high[KEEP_EEP_BIT]) begin
              next_state     = ST_ER_EEP;
              next_nvm_op    = NVM_ERASE_EEP;
              next_nvm_start = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ER_EEP: begin
          if (i_nvm_done) begin
            next_state = ST_IDLE;
          end
        end
        ST_FUSE: begin
          next_timer = timer + 1'b1;
          if (timer == FUSE_TIMER_W'(FUSE_WRITE_CYC - 1)) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      prog      <= 1'b0;
      state     <= ST_OFF;
      cmd       <= CMD_NOP;
      addr_low  <= 8'h00;
      addr_high <= 8'h00;
      addr_ext  <= 8'h00;
      data_low  <= 8'hff;
      data_high <= 8'hff;
      fuse_low  <= FUSE_LOW_RST;
      fuse_high <= FUSE_HIGH_RST;
      fuse_ext  <= FUSE_EXT_RST;
      lock      <= LOCK_ERASED;
      timer     <= '0;
      nvm_start <= 1'b0;
      nvm_op    <= NVM_NONE;
      nvm_page  <= 8'h00;
      data_out  <= 8'h00;
    end else begin
      prog      <= next_prog;
      state     <= next_state;
      cmd       <= next_cmd;
      addr_low  <= next_addr_low;
      addr_high <= next_addr_high;
      addr_ext  <= next_addr_ext;
      data_low  <= next_data_low;
      data_high <= next_data_high;
      fuse_low  <= next_fuse_low;
      fuse_high <= next_fuse_high;
      fuse_ext  <= next_fuse_ext;
      lock      <= next_lock;
      timer     <= next_timer;
      nvm_start <= next_nvm_start;
      nvm_op    <= next_nvm_op;
      nvm_page  <= next_nvm_page;
      data_out  <= next_data_out;
    end
  end

  phpp_page_mem #(
    .AW (WORD_IN_PAGE_W),
    .DW (16)
  ) u_page_buf (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_we      (buf_we),
    .i_waddr   (buf_waddr),
    .i_wdata   ({data_high, data_low}),
    .i_raddr   (i_nvm_buf_index),
    .o_rdata   (o_nvm_buf_word)
  );

  assign o_data           = data_out;
  assign o_data_oe        = prog & oe_act;
  assign o_ready_not_busy = !prog || (state == ST_IDLE);
  assign o_prog_mode      = prog;
  assign o_fuse_low       = fuse_low;
  assign o_fuse_high      = fuse_high;
  assign o_fuse_ext       = fuse_ext;
  assign o_lock           = lock;
  assign o_nvm_start      = nvm_start;
  assign o_nvm_op         = nvm_op;
  assign o_nvm_page       = nvm_page;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence seq_store(logic [7:0] c);
    prog && clean[PIN_HV] && !hv_rise && state == ST_IDLE && store_fall && cmd == c;
  endsequence

  AST_PAGE_BUSY: assert property (seq_store(CMD_WR_FLASH) |=> !o_ready_not_busy ##0 o_nvm_start
      ##0 o_nvm_page == $past({addr_high[6:0], addr_low[7]}))
    else $error("flash page store did not start a busy page program");
  AST_EEP_PAGE: assert property (seq_store(CMD_WR_EEP) |=> o_nvm_op == NVM_EEP_PAGE
      && o_nvm_page == $past({addr_high[2:0], addr_low[7:3]}))
    else $error("EEPROM page index wrong");
  AST_ERASE_BUSY: assert property (seq_store(CMD_ERASE) |=> !o_ready_not_busy
      && o_nvm_op == NVM_ERASE_FLASH)
    else $error("erase did not go busy");
  AST_FUSE_BUSY: assert property (seq_store(CMD_WR_FUSE) |=> !o_ready_not_busy [*8])
    else $error("fuse write busy too short");
  AST_OE_DRIVE: assert property (o_data_oe |-> prog && !clean[PIN_OE_N])
    else $error("data bus driven without output enable");
  AST_CMD_LOAD: assert property (prog && clean[PIN_HV] && !hv_rise && load_rise
      && action == ACT_CMD |=> cmd == $past(pin_data))
    else $error("command byte not captured");
  AST_IDLE_ACT: assert property (prog && clean[PIN_HV] && !hv_rise && load_rise
      && action == ACT_IDLE |=> $stable(cmd) && $stable(addr_low) && $stable(data_low))
    else $error("idle action changed state");
  AST_LOCK_READ: assert property (prog && oe_act && cmd == CMD_RD_FUSE && bsel == BSEL_HIGH
      |=> o_data == $past(lock))
    else $error("lock bits not returned");
  AST_KEEP_EEP: assert property (state == ST_ER_SRAM && i_nvm_done && clean[PIN_HV]
      && !fuse_high[KEEP_EEP_BIT] |=> state == ST_IDLE)
    else $error("EEPROM erased despite keep fuse");
  AST_LOCK_CLEAR: assert property (lock == LOCK_ERASED && $past(lock) != LOCK_ERASED
      && $past(state) == ST_ER_FLASH |-> $past(i_nvm_done))
    else $error("locks cleared before flash erase ended");
  AST_EXIT: assert property (!clean[PIN_HV] |=> !prog)
    else $error("programming mode kept without high voltage");
  AST_RETAIN: assert property (store_fall && !load_rise |=> $stable(cmd))
    else $error("command lost across store");
endmodule
`default_nettype wire

/* sim/phpp_array_model.sv */
// Stand-in for the memory arrays behind the programming port.
// Assumes the port shares its clock; reads answer at once.
`timescale 1ns/100ps
`default_nettype none
module phpp_array_model (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Port side.
  input  wire logic        i_start,
  input  wire logic [14:0] i_flash_addr,
  input  wire logic [10:0] i_eep_addr,
  output logic             o_done = 1'b0,
  output logic      [15:0] o_flash_data,
  output logic      [7:0]  o_eep_data
);
  int cnt = 0;
  assign o_flash_data = {1'b0, i_flash_addr};
  assign o_eep_data   = i_eep_addr[7:0];
  always @(posedge i_clock) begin
    o_done <= i_reset_n && cnt == 1;
    if (!i_reset_n) cnt <= 0;
    else if (i_start) cnt <= 40;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the programming port.
// Assumes the array model answers every started operation.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import phpp_pkg::*;
  logic         i_clock = 0;
  logic         i_reset_n = 0;
  logic  [16:0] p = PIN_IDLE;
  logic  [7:0]  od, fl, fh, fe, lk, pg, ed;
  logic         oe, rdy, pm, st, dn;
  logic  [14:0] fa;
  logic  [10:0] ea;
  logic  [15:0] fd, bw;
  logic  [6:0]  bi = 7'h00;
  phpp_nvm_op_e op;
  phpp_nvm_op_e ops[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #5 i_clock = ~i_clock;
  phpp_port #(.CAL_BYTE(8'h4d)) i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_prog_voltage(p[PIN_HV]), .i_load_strobe(p[PIN_LOAD]), .i_store_strobe_n(p[PIN_STORE_N]),
    .i_output_enable_n(p[PIN_OE_N]), .i_byte_select_high(p[PIN_SELH]),
    .i_byte_select_extended(p[PIN_SELX]), .i_strobe_action_bit0(p[PIN_ACT0]),
    .i_strobe_action_bit1(p[PIN_ACT1]), .i_page_latch_strobe(p[PIN_LATCH]),
    .i_data(p[7:0]), .o_data(od), .o_data_oe(oe), .o_ready_not_busy(rdy), .o_prog_mode(pm),
    .o_fuse_low(fl), .o_fuse_high(fh), .o_fuse_ext(fe), .o_lock(lk), .o_nvm_start(st),
    .o_nvm_op(op), .o_nvm_page(pg), .i_nvm_done(dn), .i_nvm_buf_index(bi),
    .o_nvm_buf_word(bw), .o_flash_rd_addr(fa), .i_flash_rd_data(fd), .o_eep_rd_addr(ea),
    .i_eep_rd_data(ed));
  phpp_array_model i_arr (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_start(st),
    .i_flash_addr(fa), .i_eep_addr(ea), .o_done(dn), .o_flash_data(fd), .o_eep_data(ed));
  // ****************************************************************
  // Pin tasks and checks.
  // ****************************************************************
  task automatic w(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pin(input int i, input logic v);
    p[i] = v;
    w(26);
  endtask
  task automatic ld(input logic [1:0] a, input logic [1:0] s, input logic [7:0] d);
    p[PIN_ACT1:PIN_ACT0] = a;
    p[PIN_SELX] = s[1];
    p[PIN_SELH] = s[0];
    p[7:0] = d;
    w(26);
    pin(PIN_LOAD, 1);
    pin(PIN_LOAD, 0);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    p[PIN_SELX] = s[1];
    p[PIN_SELH] = s[0];
    pin(PIN_OE_N, 0);
    chk("oe", oe, 1);
    chk("data", od, e);
    pin(PIN_OE_N, 1);
    chk("oe", oe, 0);
  endtask
  task automatic store();
    ops.delete();
    pin(PIN_STORE_N, 0);
    chk("busy", rdy, 0);
    pin(PIN_STORE_N, 1);
    for (int k = 0; k < 1000 && rdy !== 1'b1; k++) w(1);
    chk("ready", rdy, 1);
  endtask
  always @(posedge i_clock) if (st) ops.push_back(op);
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_entry_fuse_read();
    chk("mode", pm, 0);
    chk("fuse_high", fh, FUSE_HIGH_RST);
    chk("fuse_low", fl, FUSE_LOW_RST);
    chk("fuse_ext", fe, FUSE_EXT_RST);
    pin(PIN_HV, 1);
    chk("mode", pm, 1);
    w(1000);
    w(30000);
    ld(ACT_CMD, 2'h0, CMD_RD_FUSE);
    ld(ACT_IDLE, 2'h0, CMD_ERASE);
    rd(2'h0, FUSE_LOW_RST);
    rd(2'h1, LOCK_ERASED);
    rd(2'h2, FUSE_EXT_RST);
    rd(2'h3, FUSE_HIGH_RST);
  endtask
  task automatic t_flash_page();
    ld(ACT_CMD, 2'h0, CMD_WR_FLASH);
    ld(ACT_ADDR, 2'h0, 8'h34);
    ld(ACT_ADDR, 2'h1, 8'h92);
    chk("flash_addr", 16'(fa), 16'h1234);
    ld(ACT_DATA, 2'h0, 8'h78);
    ld(ACT_DATA, 2'h1, 8'h56);
    pin(PIN_LATCH, 1);
    pin(PIN_LATCH, 0);
    store();
    chk("op", 16'(ops[0]), 16'(NVM_FLASH_PAGE));
    chk("page", 16'(pg), 16'h0024);
    bi = 7'h34;
    w(1);
    chk("buf_word", bw, 16'h5678);
    ld(ACT_CMD, 2'h0, CMD_RD_FLASH);
    rd(2'h0, 8'h34);
    rd(2'h1, 8'h12);
  endtask
  task automatic t_lock_erase();
    ld(ACT_CMD, 2'h0, CMD_WR_LOCK);
    ld(ACT_DATA, 2'h0, 8'h3c);
    store();
    chk("lock", 16'(lk), 16'h003c);
    ld(ACT_CMD, 2'h0, CMD_ERASE);
    store();
    chk("n_ops", 16'(ops.size()), 16'h0003);
    chk("op0", 16'(ops[0]), 16'(NVM_ERASE_FLASH));
    chk("op2", 16'(ops[2]), 16'(NVM_ERASE_EEP));
    chk("lock", 16'(lk), 16'(LOCK_ERASED));
    chk("fuse_high", 16'(fh), 16'(FUSE_HIGH_RST));
  endtask
  task automatic t_keep_eep();
    ld(ACT_CMD, 2'h0, CMD_WR_FUSE);
    ld(ACT_DATA, 2'h0, 8'h91);
    pin(PIN_SELH, 1);
    store();
    chk("fuse_high", 16'(fh), 16'h0091);
    ld(ACT_CMD, 2'h0, CMD_ERASE);
    store();
    chk("n_ops", 16'(ops.size()), 16'h0002);
    chk("op1", 16'(ops[1]), 16'(NVM_ERASE_SRAM));
    ld(ACT_CMD, 2'h0, CMD_WR_EEP);
    ld(ACT_ADDR, 2'h1, 8'h05);
    ld(ACT_ADDR, 2'h0, 8'h4b);
    ld(ACT_DATA, 2'h0, 8'ha5);
    pin(PIN_LATCH, 1);
    pin(PIN_LATCH, 0);
    store();
    chk("op", 16'(ops[0]), 16'(NVM_EEP_PAGE));
    chk("eep_page", 16'(pg), 16'h00a9);
    bi = 7'h03;
    w(1);
    chk("eep_buf", bw, 16'h56a5);
    ld(ACT_CMD, 2'h0, CMD_RD_EEP);
    rd(2'h0, 8'h4b);
    ld(ACT_CMD, 2'h0, CMD_RD_SIG);
    rd(2'h1, 8'h4d);
    pin(PIN_HV, 0);
    chk("mode", pm, 0);
  endtask
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    w(2);
    i_reset_n = 1;
    w(8);
    t_entry_fuse_read();
    t_lock_erase();
    t_flash_page();
    t_keep_eep();
    stop_test();
  end
endmodule
`default_nettype wire
